/* File: rtl/lbp_led_pwm.sv */
// Purpose: Button-controlled LED brightness PWM with APB registers
// Assumes: Buttons already synchronous, active low; 40 MHz clock
// Notes:   led_o high means LED off (open-drain pulls low to light)
//
// Summary of operation
// - PWM period equals period counter wrap, 20 ms
// - Comparator takes level and ramp, 8 bits
// - Default range: duty equals level over 256
// - Range select: 0-99.61% or 0.39-100%
// - Hold high freezes the level counter
// - Up count to 255, one-cycle terminal pulse
// - Down count to 0, one-cycle terminal pulse
// - Hold from 3-input function of buttons
// - Direction from zero flop and plus button
// - Terminal pulse powers down PWM, forces 0%
// - Output NOR of flop and PWM; NAND
// - Delay cell delays both edges
// - Step mode: one press, one step
// - Sweep mode reaches 0/256 and 256/256
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "lbp_map.svh"
module lbp_led_pwm #(
    parameter int PERIOD_NS = `LBP_PERIOD_NS,
    parameter int CLK_NS    = `LBP_CLK_NS,
    parameter int DLY_CYC   = `LBP_DLY_CYC
) (
    input  wire logic                  clk_i,
    input  wire logic                  reset_n_i,
    input  wire logic                  ce_i,
    input  wire lbp_pkg::lbp_buttons_t btn_i,
    input  wire lbp_pkg::lbp_apb_req_t apb_i,
    output var  lbp_pkg::lbp_apb_rsp_t apb_o,
    output var  logic                  led_o,
    output var  logic                  led_oe_n_o,
    output var  logic                  pwm_o
);
    import lbp_pkg::*;

    // ****************************************************************
    // Timing derivation
    // ****************************************************************
    // Tick length: period split into 256 ramp steps, rounded down
    localparam int TICK_CYC = PERIOD_NS / (CLK_NS * 256);

    initial begin
        if (TICK_CYC < 1 || TICK_CYC > 65535) $error("lbp_led_pwm: bad period");
        if (DLY_CYC < 1 || DLY_CYC > 255) $error("lbp_led_pwm: bad delay");
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SETUP = 2'b01,
        ST_DONE  = 2'b10
    } lbp_btn_state_t;

    logic [2:0]     ctrl_r;
    logic [15:0]    tick_r;
    logic [7:0]     ramp_r;
    logic [7:0]     level_r;
    logic           term_r;
    logic           term_seen_r;
    logic           zero_r;
    logic           pwm_r;
    lbp_btn_state_t bst_r;
    logic           step_ok_r;

    logic plus;
    logic minus;
    logic nand_out;
    logic hold;
    logic dir_up;
    logic zero_path;
    logic zero_dly;
    logic tick_end;
    logic range_hi;
    logic step_mode;
    logic cmp;

    // Buttons pull pins low when pressed
    assign plus      = ~btn_i.plus_n;
    assign minus     = ~btn_i.minus_n;
    assign range_hi  = ctrl_r[`LBP_CTRL_RANGE_BIT];
    assign step_mode = ctrl_r[`LBP_CTRL_STEP_BIT];
    assign tick_end  = (tick_r == 16'(TICK_CYC - 1));

    // ****************************************************************
    // Glue gates
    // ****************************************************************
    // NAND conditioning of the raw pins: high while any button pressed
    assign nand_out  = ~(btn_i.plus_n & btn_i.minus_n);
    // Hold when no button, both buttons, software hold, or step used up
    assign hold      = ~nand_out | (plus & minus) | ctrl_r[`LBP_CTRL_SWHOLD_BIT]
                       | (step_mode & ~step_ok_r);
    // Down only while zero flop low and plus released; plus raises level
    assign dir_up    = zero_r | plus;
    // Latched top-end pulse steers the zero path; minus breaks it at once
    assign zero_path = term_seen_r & ~minus;

    lbp_edge_delay #(
        .DLY (DLY_CYC)
    ) u_dly (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .ce_i      (ce_i),
        .d_i       (zero_path),
        .q_o       (zero_dly)
    );

    // ****************************************************************
    // Period counter
    // ****************************************************************
    // Ramp advances every tick, wraps every 256 ticks = 20 ms
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            tick_r <= 16'h0000;
            ramp_r <= 8'h00;
        end else if (ce_i) begin
            if (tick_end) begin
                tick_r <= 16'h0000;
                ramp_r <= ramp_r + 8'h01;
            end else begin
                tick_r <= tick_r + 16'h0001;
            end
        end
    end

    // ****************************************************************
    // Step gate for single-press mode
    // ****************************************************************
    // One step per press; a held button gives no repeat
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            bst_r     <= ST_IDLE;
            step_ok_r <= 1'b0;
        end else if (ce_i) begin
            case (bst_r)
                ST_IDLE: begin
                    if (nand_out) begin
                        bst_r     <= ST_SETUP;
                        step_ok_r <= 1'b1;
                    end
                end
                ST_SETUP: begin
                    if (tick_end) begin
                        bst_r     <= ST_DONE;
                        step_ok_r <= 1'b0;
                    end
                end
                ST_DONE: begin
                    if (!nand_out) begin
                        bst_r <= ST_IDLE;
                    end
                end
                default: begin
                    bst_r     <= ST_IDLE;
                    step_ok_r <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Level counter
    // ****************************************************************
    // Moves one count per tick so a held button sweeps in about 20 ms
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            level_r <= `LBP_LEVEL_RST;
            term_r  <= 1'b0;
        end else if (ce_i) begin
            term_r <= 1'b0;
            if (apb_i.psel && apb_i.penable && apb_i.pwrite
                && apb_i.paddr == `LBP_LEVEL_OFS) begin
                level_r <= apb_i.pwdata[7:0];
            end else if (tick_end && !hold) begin
                if (dir_up) begin
                    if (level_r == 8'hff) begin
                        term_r <= 1'b1;
                    end else begin
                        level_r <= level_r + 8'h01;
                    end
                end else begin
                    if (level_r == 8'h00) begin
                        term_r <= 1'b1;
                    end else begin
                        level_r <= level_r - 8'h01;
                    end
                end
            end
        end
    end

    // ****************************************************************
    // Zero duty flop
    // ****************************************************************
    // Terminal pulse at the top latches zero; minus releases it
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            term_seen_r <= 1'b0;
            zero_r      <= 1'b0;
        end else if (ce_i) begin
            if (term_r && dir_up) begin
                term_seen_r <= 1'b1;
            end else if (minus) begin
                term_seen_r <= 1'b0;
            end
            zero_r <= zero_dly;
        end
    end

    // ****************************************************************
    // Comparator and output
    // ****************************************************************
    // High range adds one step so full scale reaches 100%
    always_comb begin
        if (range_hi) begin
            cmp = ({1'b0, ramp_r} <= {1'b0, level_r});
        end else begin
            cmp = (ramp_r < level_r);
        end
    end

    // Power-down from terminal pulse blanks the PWM; NOR forms the pin
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pwm_r      <= 1'b0;
            pwm_o      <= 1'b0;
            led_o      <= 1'b1;
            led_oe_n_o <= 1'b1;
        end else if (ce_i) begin
            pwm_r      <= cmp & ~term_r;
            pwm_o      <= pwm_r;
            led_o      <= ~(zero_r | pwm_r);
            led_oe_n_o <= ~(zero_r | pwm_r); // Open drain: drive low only
        end
    end

    // ****************************************************************
    // APB slave
    // ****************************************************************
    // Zero wait states; unmapped addresses raise pslverr
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            ctrl_r <= `LBP_CTRL_RST;
        end else if (ce_i && apb_i.psel && apb_i.penable && apb_i.pwrite
                     && apb_i.paddr == `LBP_CTRL_OFS) begin
            ctrl_r <= apb_i.pwdata[2:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            apb_o <= '0;
        end else if (ce_i) begin
            apb_o.pready  <= apb_i.psel && !apb_i.penable;
            apb_o.pslverr <= 1'b0;
            apb_o.prdata  <= 32'h0000_0000;
            if (apb_i.psel && !apb_i.penable) begin
                case (apb_i.paddr)
                    `LBP_CTRL_OFS:   apb_o.prdata <= {29'h0, ctrl_r};
                    `LBP_STATUS_OFS: apb_o.prdata <= {27'h0, term_seen_r, hold,
                                                      dir_up, zero_r, pwm_r};
                    `LBP_LEVEL_OFS:  apb_o.prdata <= {24'h0, level_r};
                    `LBP_PERIOD_OFS: apb_o.prdata <= {24'h0, ramp_r};
                    default:         apb_o.pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule // lbp_led_pwm
`default_nettype wire

/* File: rtl/lbp_map.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 40 MHz core clock
// Notes:   Definitions only
`ifndef LBP_MAP_SVH
`define LBP_MAP_SVH

// ****************************************************************
// Register offsets (APB byte addresses)
// ****************************************************************
`define LBP_CTRL_OFS        12'h000
`define LBP_STATUS_OFS      12'h004
`define LBP_LEVEL_OFS       12'h008
`define LBP_PERIOD_OFS      12'h00c

// ****************************************************************
// Field positions
// ****************************************************************
`define LBP_CTRL_RANGE_BIT  0
`define LBP_CTRL_STEP_BIT   1
`define LBP_CTRL_SWHOLD_BIT 2
`define LBP_ST_OUT_BIT      0
`define LBP_ST_ZERO_BIT     1
`define LBP_ST_DIR_BIT      2
`define LBP_ST_HOLD_BIT     3
`define LBP_ST_TERM_BIT     4

// ****************************************************************
// Reset values
// ****************************************************************
`define LBP_CTRL_RST        3'h0
`define LBP_LEVEL_RST       8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define LBP_PERIOD_NS       20000000
`define LBP_CLK_NS          25
`define LBP_DLY_CYC         4

`endif

/* File: rtl/lbp_pkg.sv */
// Purpose: Types shared by the brightness PWM files
// Assumes: Nothing
// Notes:   Constants live in lbp_map.svh
package lbp_pkg;

    // APB request from master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } lbp_apb_req_t;

    // APB answer to master
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } lbp_apb_rsp_t;

    // Button pair, active low at the pins
    typedef struct packed {
        logic plus_n;
        logic minus_n;
    } lbp_buttons_t;

endpackage

/* File: rtl/lbp_edge_delay.sv */
// Purpose: Edge delay cell delaying both edges of its input
// Assumes: Clock-enabled synchronous logic
// Notes:   Output follows input after DLY stable cycles
`timescale 1ns/1ps
`default_nettype none
module lbp_edge_delay #(
    parameter int DLY = 4
) (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic ce_i,
    input  wire logic d_i,
    output var  logic q_o
);
    import lbp_pkg::*;

    initial begin
        if (DLY < 1 || DLY > 255) $error("lbp_edge_delay: DLY out of range");
    end

    logic [7:0] cnt_r;

    // Both rising and falling edges wait DLY cycles; glitches shorter are absorbed
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            cnt_r <= 8'h00;
            q_o   <= 1'b0;
        end else if (ce_i) begin
            if (d_i == q_o) begin
                cnt_r <= 8'h00;
            end else if (cnt_r == 8'(DLY - 1)) begin
                cnt_r <= 8'h00;
                q_o   <= d_i;
            end else begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end
endmodule // lbp_edge_delay
`default_nettype wire

/* File: verification/lbp_led_pwm_chk.sv */
// Purpose: Port assertions for the brightness PWM
// Assumes: Zero-wait APB slave, ce_i high
// Notes:   Bound to lbp_led_pwm below
`timescale 1ns/1ps
`default_nettype none
module lbp_led_pwm_chk (
    input  wire logic                  clk_i,
    input  wire logic                  reset_n_i,
    input  wire logic                  ce_i,
    input  wire lbp_pkg::lbp_buttons_t btn_i,
    input  wire lbp_pkg::lbp_apb_req_t apb_i,
    input  wire lbp_pkg::lbp_apb_rsp_t apb_o,
    input  wire logic                  led_o,
    input  wire logic                  led_oe_n_o,
    input  wire logic                  pwm_o
);
    import lbp_pkg::*;
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // Setup phase, then the answered access phase
    sequence s_setup;
        apb_i.psel && !apb_i.penable && ce_i;
    endsequence
    sequence s_answer;
        apb_i.psel && apb_i.penable && apb_o.pready;
    endsequence
    // Reset must win even while reset is low, so no disable here
    a_reset_outs: assert property (disable iff (1'b0) (!reset_n_i && ce_i) |=>
        (apb_o == '0 && led_o && led_oe_n_o && !pwm_o)) else $error("reset values wrong");
    a_pready_one: assert property (s_setup |=> apb_o.pready) else $error("no answer");
    a_pready_pulse: assert property (apb_o.pready |=> !apb_o.pready) else $error("long ready");
    a_pready_cause: assert property (apb_o.pready |-> $past(apb_i.psel && !apb_i.penable))
        else $error("ready without setup");
    a_unmapped_err: assert property ((apb_o.pready && apb_i.paddr > 12'h00c) |->
        apb_o.pslverr) else $error("unmapped accepted");
    a_mapped_ok: assert property (s_answer ##0 (apb_i.paddr <= 12'h00c
        && apb_i.paddr[1:0] == 2'b00) |-> !apb_o.pslverr)
        else $error("mapped refused");
    a_rdata_upper: assert property (s_answer ##0 !apb_i.pwrite |-> apb_o.prdata[31:8] == '0)
        else $error("read data upper bits set");
    a_drain_enable: assert property (led_oe_n_o == led_o) else $error("drain enable");
    a_led_nor: assert property (pwm_o |-> ##[0:2] !led_o) else $error("nor output");
endmodule // lbp_led_pwm_chk
bind lbp_led_pwm lbp_led_pwm_chk lbp_led_pwm_chk_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .ce_i(ce_i), .btn_i(btn_i), .apb_i(apb_i), .apb_o(apb_o), .led_o(led_o),
    .led_oe_n_o(led_oe_n_o), .pwm_o(pwm_o));
`default_nettype wire

/* File: verification/lbp_btn_led_model.sv */
// Purpose: Two push buttons and the open-drain LED pin
// Assumes: Buttons short to ground when pressed
// Notes:   Pull-ups hold released lines high
`timescale 1ns/1ps
`default_nettype none
module lbp_btn_led_model (
    input  wire logic                  plus_press_i,
    input  wire logic                  minus_press_i,
    input  wire logic                  led_i,
    input  wire logic                  led_oe_n_i,
    output wire lbp_pkg::lbp_buttons_t btn_o,
    output wire logic                  led_pin_o
);
    import lbp_pkg::*;
    // Released buttons read high through their pull-ups
    assign btn_o = {~plus_press_i, ~minus_press_i};
    // Pin pulled up unless the drain is on and pulling low
    assign led_pin_o = (!led_oe_n_i && !led_i) ? 1'b0 : 1'b1;
endmodule // lbp_btn_led_model
`default_nettype wire

/* File: verification/lbp_led_pwm_tb.sv */
// Purpose: Self-checking bench for the brightness PWM
// Assumes: Short period, 4 cycles per ramp tick
// Notes:   ce_i tied high
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
    $display("MISMATCH %s exp %0h got %0h", nm, ex, got); err_total++; end end
module lbp_led_pwm_tb;
    import lbp_pkg::*;
    localparam int PER = 1024; // Ramp wrap in cycles
    logic         clk_i = 0, reset_n_i = 0, plus = 0, minus = 0;
    logic         led_pin, led_o, led_oe_n_o, pwm_o, e;
    logic [31:0]  q;
    lbp_apb_req_t apb_i = '0;
    lbp_apb_rsp_t apb_o;
    lbp_buttons_t btn;
    int           err_total = 0, cmp_count = 0, cyc = 0;
    always #12.5 clk_i = ~clk_i;
    lbp_led_pwm #(.PERIOD_NS(25600)) lbp_led_pwm_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .ce_i(1'b1), .btn_i(btn), .apb_i(apb_i), .apb_o(apb_o), .led_o(led_o),
        .led_oe_n_o(led_oe_n_o), .pwm_o(pwm_o));
    lbp_btn_led_model lbp_btn_led_model_inst (.plus_press_i(plus), .minus_press_i(minus),
        .led_i(led_o), .led_oe_n_i(led_oe_n_o), .btn_o(btn), .led_pin_o(led_pin));
    // ****************
    // Tasks
    // ****************
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Hang guard, well above the planned run
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            complete_run();
        end
    end
    // One APB transfer, held until pready is sampled
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk_i);
        apb_i.penable <= 1'b1;
        n = 0;
        do begin @(posedge clk_i); n++; end while (apb_o.pready !== 1'b1 && n < 16);
        if (n >= 16) err_total++;
        q = apb_o.prdata;
        e = apb_o.pslverr;
        apb_i.psel <= 1'b0;
        apb_i.penable <= 1'b0;
    endtask
    task automatic press(input logic p, input logic m, input int n);
        plus <= p;
        minus <= m;
        repeat (n) @(posedge clk_i);
        plus <= 1'b0;
        minus <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask
    // Count cycles with the chosen signal high over one wrap
    task automatic count(input logic use_pin, output int hi);
        hi = 0;
        repeat (PER) begin @(posedge clk_i); hi += use_pin ? led_pin : pwm_o; end
    endtask
    task automatic t_regs();
        `CHK("idle pin", 1'b1, led_pin)
        bus(0, 12'h000, 0); `CHK("ctrl reset", 32'h0, q)
        bus(0, 12'h008, 0); `CHK("level reset", 32'h0, q)
        bus(0, 12'h010, 0); `CHK("unmapped err", 1'b1, e)
        bus(1, 12'h008, 32'h3c);
        bus(1, 12'h00c, 32'h55);
        bus(0, 12'h008, 0); `CHK("level rw", 32'h3c, q)
    endtask
    task automatic duty(input logic [7:0] lv, input logic [31:0] ctl, input int ex);
        int hi;
        bus(1, 12'h000, ctl);
        bus(1, 12'h008, {24'h0, lv});
        repeat (PER) @(posedge clk_i);
        count(1'b0, hi);
        `CHK("pwm high cycles", ex, hi)
    endtask
    task automatic t_duty();
        duty(8'h00, 0, 0);
        duty(8'h40, 0, 256);
        duty(8'hff, 0, 1020);
        duty(8'h40, 1, 260);
        duty(8'hff, 1, 1024);
    endtask
    task automatic t_buttons();
        bus(1, 12'h000, 0);
        bus(1, 12'h008, 32'h30);
        press(1, 1, 100);
        bus(0, 12'h008, 0); `CHK("both held", 32'h30, q)
        bus(1, 12'h000, 4);
        press(0, 1, 100);
        bus(0, 12'h008, 0); `CHK("soft hold", 32'h30, q)
        bus(1, 12'h000, 2);
        press(1, 0, 40);
        bus(0, 12'h008, 0); `CHK("step plus", 32'h31, q)
        press(0, 1, 40);
        bus(0, 12'h008, 0); `CHK("step minus", 32'h30, q)
        bus(1, 12'h000, 0);
        press(0, 1, 40);
        bus(0, 12'h008, 0); `CHK("minus lowers", 1'b1, q < 32'h30)
    endtask
    // Plus sweeps to the top and latches the pin low; minus releases it
    task automatic t_sweep();
        int hi;
        bus(1, 12'h008, 32'hf8);
        press(1, 0, 100);
        bus(0, 12'h008, 0); `CHK("swept to top", 32'hff, q)
        count(1'b1, hi); `CHK("zero latched pin", 0, hi)
        press(0, 1, 40);
        bus(0, 12'h008, 0);
        count(1'b1, hi); `CHK("pin after minus", PER - 4 * int'(q[7:0]), hi)
    endtask
    // ****************
    // Main sequence
    // ****************
    initial begin
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_regs();
        t_duty();
        t_buttons();
        t_sweep();
        complete_run();
    end
endmodule // lbp_led_pwm_tb
`default_nettype wire
